// ### design/vsq_cfg.svh
// Register indexes, field positions, reset values and counts for the sequencer.
`ifndef VSQ_CFG_SVH
`define VSQ_CFG_SVH

// ==========================================================================
// Register indexes on the sequencer data port
// ==========================================================================
`define VSQ_IDX_W          3
`define VSQ_IDX_CLK        3'h1
`define VSQ_IDX_MASK       3'h2
`define VSQ_IDX_FONT       3'h3

// ==========================================================================
// Reset values and readable bits
// ==========================================================================
`define VSQ_CLK_RST        8'h00
`define VSQ_MASK_RST       4'h0
`define VSQ_FONT_RST       6'h00
`define VSQ_CLK_RD_MASK    8'h3d
`define VSQ_MASK_RD_MASK   8'h0f
`define VSQ_FONT_RD_MASK   8'h3f

// ==========================================================================
// Field positions
// ==========================================================================
`define VSQ_BIT_NARROW     0
`define VSQ_BIT_SLOAD      2
`define VSQ_BIT_DIV2       3
`define VSQ_BIT_SHIFT4     4

// ==========================================================================
// Counts
// ==========================================================================
`define VSQ_DOTS_NARROW    5'h08
`define VSQ_DOTS_WIDE      5'h09
`define VSQ_SEG_LSB        13
`define VSQ_MEM_AW         18
`define VSQ_LOW_MEM_LSB    16
`define VSQ_PAN_WRAP       4'h8

`endif

// ### design/vsq_char_timer.sv
// Dot clock divide, character clock and shift register load timing.
`timescale 1ns/1ns
`include "vsq_cfg.svh"
module vsq_char_timer
  import vsq_pkg::*;
(
  vsq_ctl_if.tim ci
);
  logic       phase_ff,   nxt_phase;
  logic [4:0] dot_cnt_ff, nxt_dot_cnt;
  logic [1:0] chr_cnt_ff, nxt_chr_cnt;
  logic       dot_en_ff,  nxt_dot_en;
  logic       char_ff,    nxt_char;
  logic       load_ff,    nxt_load;
  logic       step;
  logic       last_dot;
  logic       last_chr;
  logic [4:0] dots;
  logic [1:0] chr_lim;

  always_comb begin
    step     = ~ci.clk_cfg.div2 | phase_ff;
    nxt_phase = ci.clk_cfg.div2 ? ~phase_ff : 1'b0;
    dots     = ci.clk_cfg.narrow ? `VSQ_DOTS_NARROW : `VSQ_DOTS_WIDE;
    last_dot = dot_cnt_ff >= dots - 5'h01;
    case (ci.clk_cfg.ld_rate)
      VSQ_LD_SECOND: chr_lim = 2'h1;
      VSQ_LD_FOURTH: chr_lim = 2'h3;
      default:       chr_lim = 2'h0;
    endcase
    last_chr    = chr_cnt_ff >= chr_lim;
    nxt_dot_cnt = dot_cnt_ff;
    nxt_chr_cnt = chr_cnt_ff;
    if (step) begin
      nxt_dot_cnt = last_dot ? 5'h00 : dot_cnt_ff + 5'h01;
      if (last_dot) begin
        nxt_chr_cnt = last_chr ? 2'h0 : chr_cnt_ff + 2'h1;
      end
    end
    nxt_dot_en = step;
    nxt_char   = step & last_dot;
    nxt_load   = step & last_dot & last_chr;
  end

  always_ff @(posedge ci.clk or negedge ci.rst_sync_n) begin
    if (!ci.rst_sync_n) begin
      phase_ff   <= 1'b0;
      dot_cnt_ff <= 5'h00;
      chr_cnt_ff <= 2'h0;
      dot_en_ff  <= 1'b0;
      char_ff    <= 1'b0;
      load_ff    <= 1'b0;
    end else begin
      phase_ff   <= nxt_phase;
      dot_cnt_ff <= nxt_dot_cnt;
      chr_cnt_ff <= nxt_chr_cnt;
      dot_en_ff  <= nxt_dot_en;
      char_ff    <= nxt_char;
      load_ff    <= nxt_load;
    end
  end

  assign ci.dot_en     = dot_en_ff;
  assign ci.char_clk   = char_ff;
  assign ci.shift_load = load_ff;

  // Checking helpers: cycles since the settings last moved, and character
  // clocks seen since the last reload.
  logic [5:0] cfg_age_ff;
  logic [2:0] since_ff;
  always_ff @(posedge ci.clk or negedge ci.rst_sync_n) begin
    if (!ci.rst_sync_n) begin
      cfg_age_ff <= 6'h00;
      since_ff   <= 3'h0;
    end else begin
      cfg_age_ff <= $changed(ci.clk_cfg) ? 6'h00 :
                    (cfg_age_ff == 6'h3f ? cfg_age_ff : cfg_age_ff + 6'h01);
      if (char_ff) begin
        since_ff <= load_ff ? 3'h0 : since_ff + 3'h1;
      end
    end
  end

  dot_halved_a: assert property (@(posedge ci.clk)
    disable iff (!ci.rst_sync_n)
    (cfg_age_ff == 6'h3f && ci.clk_cfg.div2 && dot_en_ff) |=> !dot_en_ff)
    else $error("dot enable not halved");

  char_len_a: assert property (@(posedge ci.clk)
    disable iff (!ci.rst_sync_n)
    (cfg_age_ff == 6'h3f && ci.clk_cfg.div2 && !ci.clk_cfg.narrow
     && char_ff) |-> ##18 (char_ff || cfg_age_ff < 6'h12))
    else $error("doubled wide character not 18 clocks");

  load_rate_a: assert property (@(posedge ci.clk)
    disable iff (!ci.rst_sync_n)
    (cfg_age_ff == 6'h3f && load_ff && char_ff)
      |-> since_ff == {1'b0, chr_lim})
    else $error("reload spacing differs from rate");
endmodule

// ### design/vsq_ctl_if.sv
// Signals between the sequencer register bank and its two helpers.
`timescale 1ns/1ns
`include "vsq_cfg.svh"
interface vsq_ctl_if
  import vsq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_sync_n
);
  vsq_clk_cfg_s             clk_cfg;
  logic                     dot_en;
  logic                     char_clk;
  logic                     shift_load;
  logic                     mem_wr;
  logic                     mem_rd;
  logic [`VSQ_MEM_AW-1:0]   mem_addr;
  logic [3:0]               plane_mask;
  logic                     ext_mem_en;
  logic [3:0]               plane_we;
  logic                     rd_ok;

  modport top (input clk, rst_sync_n, dot_en, char_clk, shift_load,
               plane_we, rd_ok,
               output clk_cfg, mem_wr, mem_rd, mem_addr, plane_mask,
               ext_mem_en);
  modport tim (input clk, rst_sync_n, clk_cfg,
               output dot_en, char_clk, shift_load);
  modport wg  (input clk, rst_sync_n, mem_wr, mem_rd, mem_addr,
               plane_mask, ext_mem_en,
               output plane_we, rd_ok);
endinterface

// ### design/vsq_pkg.sv
// Types shared by the sequencer modules.
package vsq_pkg;

  // ========================================================================
  // Shift register reload rate, Gray coded along increasing period
  // ========================================================================
  typedef enum logic [1:0] {
    VSQ_LD_EACH   = 2'b00,
    VSQ_LD_SECOND = 2'b01,
    VSQ_LD_FOURTH = 2'b11
  } vsq_ld_rate_e;

  typedef logic [2:0] vsq_font_t;

  typedef struct packed {
    logic         div2;
    logic         narrow;
    vsq_ld_rate_e ld_rate;
  } vsq_clk_cfg_s;

endpackage

// ### design/vsq_seq_regs.sv
// Sequencer clocking, plane mask and font select registers with their uses.
`timescale 1ns/1ns
`include "vsq_cfg.svh"
module vsq_seq_regs
  import vsq_pkg::*;
(
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Sequencer index and data ports.
  input  wire logic                   host_wr,
  input  wire logic                   host_rd,
  input  wire logic                   host_sel_data,
  input  wire logic [7:0]             host_wdata,
  output logic      [7:0]             host_rdata,
  output logic                        host_rvalid,
  // Settings held by neighbouring blocks.
  input  wire logic                   ext_mem_en,
  input  wire logic                   force_8dot,
  // Processor memory path.
  input  wire logic                   mem_wr,
  input  wire logic                   mem_rd,
  input  wire logic [`VSQ_MEM_AW-1:0] mem_addr,
  output logic      [3:0]             plane_we,
  output logic                        mem_rd_ok,
  // Text attribute path.
  input  wire logic [7:0]             attr_in,
  input  wire logic [3:0]             pan_in,
  output logic      [15:0]            font_offset,
  output logic                        fg_bright,
  output logic                        font_split,
  output logic      [3:0]             pan_shift,
  // Horizontal timing and shift register control.
  output logic                        dot_en,
  output logic                        char_clk,
  output logic                        shift_load,
  output logic                        narrow_char
);

  // ========================================================================
  // Reset release
  // ========================================================================
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ========================================================================
  // Functions
  // ========================================================================
  // Map number of a font field; only maps 0 and 4 exist without extended
  // memory.
  function automatic vsq_font_t font_map(input logic [1:0] lo,
                                         input logic       hi,
                                         input logic       ext);
    return ext ? {hi, lo} : {hi, 2'b00};
  endfunction

  // Byte offset in plane 2 of a map: segment number times 8K.
  function automatic logic [15:0] font_base(input vsq_font_t m);
    return {m[1:0], m[2], 13'h0000};
  endfunction

  // ========================================================================
  // Register bank
  // ========================================================================
  logic [`VSQ_IDX_W-1:0] idx_ff,   nxt_idx;
  logic [7:0]            clk_ff,   nxt_clk;
  logic [3:0]            mask_ff,  nxt_mask;
  logic [5:0]            font_ff,  nxt_font;
  logic [7:0]            rdata_ff, nxt_rdata;
  logic                  rvalid_ff, nxt_rvalid;

  always_comb begin
    nxt_idx    = idx_ff;
    nxt_clk    = clk_ff;
    nxt_mask   = mask_ff;
    nxt_font   = font_ff;
    nxt_rvalid = host_rd;
    nxt_rdata  = 8'h00;
    if (host_wr && !host_sel_data) begin
      nxt_idx = host_wdata[`VSQ_IDX_W-1:0];
    end
    if (host_wr && host_sel_data) begin
      case (idx_ff)
        `VSQ_IDX_CLK:  nxt_clk  = host_wdata & `VSQ_CLK_RD_MASK;
        `VSQ_IDX_MASK: nxt_mask = host_wdata[3:0];
        `VSQ_IDX_FONT: nxt_font = host_wdata[5:0];
        default:       nxt_clk  = clk_ff;
      endcase
    end
    if (host_rd && !host_sel_data) begin
      nxt_rdata = {5'h00, idx_ff};
    end else if (host_rd) begin
      case (idx_ff)
        `VSQ_IDX_CLK:  nxt_rdata = clk_ff & `VSQ_CLK_RD_MASK;
        `VSQ_IDX_MASK: nxt_rdata = {4'h0, mask_ff};
        `VSQ_IDX_FONT: nxt_rdata = {2'h0, font_ff};
        default:       nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      idx_ff    <= '0;
      clk_ff    <= `VSQ_CLK_RST;
      mask_ff   <= `VSQ_MASK_RST;
      font_ff   <= `VSQ_FONT_RST;
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      idx_ff    <= nxt_idx;
      clk_ff    <= nxt_clk;
      mask_ff   <= nxt_mask;
      font_ff   <= nxt_font;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign host_rdata  = rdata_ff;
  assign host_rvalid = rvalid_ff;

  // ========================================================================
  // Clocking settings to the character timer
  // ========================================================================
  vsq_ctl_if ci (
    .clk        (clk),
    .rst_sync_n (rst_sync_ff)
  );

  logic narrow_eff;

  always_comb begin
    narrow_eff = clk_ff[`VSQ_BIT_NARROW] | force_8dot;
    ci.clk_cfg.div2   = clk_ff[`VSQ_BIT_DIV2];
    ci.clk_cfg.narrow = narrow_eff;
    if (clk_ff[`VSQ_BIT_SHIFT4]) begin
      ci.clk_cfg.ld_rate = VSQ_LD_FOURTH;
    end else if (clk_ff[`VSQ_BIT_SLOAD]) begin
      ci.clk_cfg.ld_rate = VSQ_LD_SECOND;
    end else begin
      ci.clk_cfg.ld_rate = VSQ_LD_EACH;
    end
  end

  // Memory write and read path settings.
  assign ci.mem_wr     = mem_wr;
  assign ci.mem_rd     = mem_rd;
  assign ci.mem_addr   = mem_addr;
  assign ci.plane_mask = mask_ff;
  assign ci.ext_mem_en = ext_mem_en;

  vsq_char_timer u_timer (
    .ci (ci.tim)
  );

  vsq_write_gate u_gate (
    .ci (ci.wg)
  );

  assign dot_en     = ci.dot_en;
  assign char_clk   = ci.char_clk;
  assign shift_load = ci.shift_load;
  assign plane_we   = ci.plane_we;
  assign mem_rd_ok  = ci.rd_ok;

  // ========================================================================
  // Font selection, intensity and panning
  // ========================================================================
  vsq_font_t   map_a;
  vsq_font_t   map_b;
  logic        split;
  logic [15:0] off_ff,    nxt_off;
  logic        bright_ff, nxt_bright;
  logic        split_ff,  nxt_split;
  logic [3:0]  pan_ff,    nxt_pan;
  logic        narrow_ff, nxt_narrow;

  always_comb begin
    map_a      = font_map(font_ff[1:0], font_ff[4], ext_mem_en);
    map_b      = font_map(font_ff[3:2], font_ff[5], ext_mem_en);
    split      = map_a != map_b;
    nxt_split  = split;
    nxt_bright = split ? 1'b0 : attr_in[3];
    nxt_off    = (split && !attr_in[3]) ? font_base(map_b)
                                        : font_base(map_a);
    nxt_narrow = narrow_eff;
    if (narrow_eff) begin
      nxt_pan = {1'b0, pan_in[2:0]};
    end else if (pan_in < `VSQ_PAN_WRAP) begin
      nxt_pan = pan_in + 4'h1;
    end else begin
      nxt_pan = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      off_ff    <= 16'h0000;
      bright_ff <= 1'b0;
      split_ff  <= 1'b0;
      pan_ff    <= 4'h0;
      narrow_ff <= 1'b0;
    end else begin
      off_ff    <= nxt_off;
      bright_ff <= nxt_bright;
      split_ff  <= nxt_split;
      pan_ff    <= nxt_pan;
      narrow_ff <= nxt_narrow;
    end
  end

  assign font_offset = off_ff;
  assign fg_bright   = bright_ff;
  assign font_split  = split_ff;
  assign pan_shift   = pan_ff;
  assign narrow_char = narrow_ff;

  // ========================================================================
  // Checks
  // ========================================================================
  mask_readback_a: assert property (@(posedge clk)
    disable iff (!rst_sync_ff)
    (host_wr && host_sel_data && idx_ff == `VSQ_IDX_MASK
     ##1 (host_rd && host_sel_data && !host_wr))
      |=> (rvalid_ff && rdata_ff == ($past(host_wdata, 2)
                                     & `VSQ_MASK_RD_MASK)))
    else $error("plane mask readback wrong");

  intensity_a: assert property (@(posedge clk)
    disable iff (!rst_sync_ff)
    (!split) |=> (bright_ff == $past(attr_in[3]) && !split_ff))
    else $error("attribute bit 3 not intensity for equal fonts");

  ext_off_a: assert property (@(posedge clk)
    disable iff (!rst_sync_ff)
    (!ext_mem_en) |=> off_ff[15:14] == 2'h0)
    else $error("font beyond maps 0 and 4 without extended memory");

  font_map_a: assert property (@(posedge clk)
    disable iff (!rst_sync_ff)
    (ext_mem_en && split && !attr_in[3])
      |=> off_ff == {$past(font_ff[3:2]), $past(font_ff[5]), 13'h0000})
    else $error("secondary font offset wrong");

  force_narrow_a: assert property (@(posedge clk)
    disable iff (!rst_sync_ff)
    (force_8dot) |=> (narrow_ff && pan_ff == {1'b0, $past(pan_in[2:0])}))
    else $error("forced 8-dot not applied");

  wide_pan_a: assert property (@(posedge clk)
    disable iff (!rst_sync_ff)
    (!narrow_eff && pan_in == `VSQ_PAN_WRAP) |=> pan_ff == 4'h0)
    else $error("9-dot pan wrap wrong");

  font_pri_a: assert property (@(posedge clk)
    disable iff (!rst_sync_ff)
    (ext_mem_en && (!split || attr_in[3]))
      |=> off_ff == {$past(font_ff[1:0]), $past(font_ff[4]), 13'h0000})
    else $error("primary font offset wrong");

  rsvd_zero_a: assert property (@(posedge clk)
    disable iff (!rst_sync_ff)
    (host_rd && host_sel_data && idx_ff == `VSQ_IDX_CLK)
      |=> (rdata_ff & ~`VSQ_CLK_RD_MASK) == 8'h00)
    else $error("reserved clocking bits not zero");

  unmapped_wr_a: assert property (@(posedge clk)
    disable iff (!rst_sync_ff)
    (host_wr && host_sel_data && idx_ff > `VSQ_IDX_FONT)
      |=> $stable({clk_ff, mask_ff, font_ff}))
    else $error("write to unmapped index changed a register");

endmodule

// ### design/vsq_write_gate.sv
// Processor access gate: plane write enables and the 64KB window.
`timescale 1ns/1ns
`include "vsq_cfg.svh"
module vsq_write_gate
  import vsq_pkg::*;
(
  vsq_ctl_if.wg ci
);
  logic [3:0] we_ff, nxt_we;
  logic       rd_ff, nxt_rd;
  logic       in_win;

  always_comb begin
    in_win = ci.ext_mem_en
             || ci.mem_addr[`VSQ_MEM_AW-1:`VSQ_LOW_MEM_LSB] == 2'h0;
    nxt_we = (ci.mem_wr && in_win) ? ci.plane_mask : 4'h0;
    nxt_rd = ci.mem_rd && in_win;
  end

  always_ff @(posedge ci.clk or negedge ci.rst_sync_n) begin
    if (!ci.rst_sync_n) begin
      we_ff <= 4'h0;
      rd_ff <= 1'b0;
    end else begin
      we_ff <= nxt_we;
      rd_ff <= nxt_rd;
    end
  end

  assign ci.plane_we = we_ff;
  assign ci.rd_ok    = rd_ff;

  plane_mask_a: assert property (@(posedge ci.clk)
    disable iff (!ci.rst_sync_n)
    (ci.mem_wr && ci.mem_addr[`VSQ_MEM_AW-1:`VSQ_LOW_MEM_LSB] == 2'h0)
      |=> we_ff == $past(ci.plane_mask))
    else $error("plane write enables differ from mask");

  high_mem_a: assert property (@(posedge ci.clk)
    disable iff (!ci.rst_sync_n)
    (!ci.ext_mem_en && ci.mem_addr[`VSQ_MEM_AW-1:`VSQ_LOW_MEM_LSB] != 2'h0)
      |=> (we_ff == 4'h0 && !rd_ff))
    else $error("access above 64KB not blocked");

  read_free_a: assert property (@(posedge ci.clk)
    disable iff (!ci.rst_sync_n)
    (ci.mem_rd && ci.plane_mask == 4'h0 && ci.ext_mem_en) |=> rd_ff)
    else $error("read gated by plane mask");
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the sequencer register bank and its timing.
`timescale 1ns/1ns
`include "vsq_cfg.svh"
module tb_top;
  import vsq_pkg::*;

  // ==========================================================================
  // Design signals and model state
  // ==========================================================================
  logic        clk, rst_n, host_wr, host_rd, host_sel_data;
  logic [7:0]  host_wdata, host_rdata, attr_in;
  logic        host_rvalid, ext_mem_en, force_8dot, mem_wr, mem_rd;
  logic [17:0] mem_addr;
  logic [3:0]  plane_we, pan_in, pan_shift, pe;
  logic        mem_rd_ok, fg_bright, font_split, dot_en, char_clk;
  logic        shift_load, narrow_char, ok, nar, spl;
  logic [15:0] font_offset;
  logic [7:0]  reg_m [8];
  logic [2:0]  fa, fb;
  int          bad_count, n_compared, n, k, c;

  vsq_seq_regs i_vsq_seq_regs (
    .clk(clk), .rst_n(rst_n), .host_wr(host_wr), .host_rd(host_rd),
    .host_sel_data(host_sel_data), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .ext_mem_en(ext_mem_en), .force_8dot(force_8dot),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .plane_we(plane_we), .mem_rd_ok(mem_rd_ok), .attr_in(attr_in),
    .pan_in(pan_in), .font_offset(font_offset), .fg_bright(fg_bright),
    .font_split(font_split), .pan_shift(pan_shift), .dot_en(dot_en),
    .char_clk(char_clk), .shift_load(shift_load),
    .narrow_char(narrow_char)
  );

  always #2 clk = ~clk;

  // ==========================================================================
  // Checking and bus tasks
  // ==========================================================================
  task automatic summarize;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] rmask(input int i);
    case (i)
      1: return 8'h3d;
      2: return 8'h0f;
      3: return 8'h3f;
      default: return 8'h00;
    endcase
  endfunction

  // A gap cycle follows each strobe so it is never lowered and raised at once.
  task automatic hw(input logic sel, input logic [7:0] d);
    host_wr = 1'b1;
    host_sel_data = sel;
    host_wdata = d;
    @(posedge clk);
    #1;
    host_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic hr(input logic sel, input logic [7:0] e);
    host_rd = 1'b1;
    host_sel_data = sel;
    @(posedge clk);
    #1;
    host_rd = 1'b0;
    chk(32'(host_rvalid), 32'h1);
    chk(32'(host_rdata), 32'(e));
    @(posedge clk);
    #1;
  endtask

  task automatic wreg(input int i, input logic [7:0] d);
    hw(1'b0, 8'(i));
    hw(1'b1, d);
    reg_m[i] = d & rmask(i);
  endtask

  task automatic rreg(input int i);
    hw(1'b0, 8'(i));
    hr(1'b0, 8'(i));
    hr(1'b1, reg_m[i]);
  endtask

  // Writes a data register and reads it back on the very next edge.
  task automatic wr_rd(input int i, input logic [7:0] d);
    hw(1'b0, 8'(i));
    host_wr = 1'b1;
    host_sel_data = 1'b1;
    host_wdata = d;
    @(posedge clk);
    #1;
    host_wr = 1'b0;
    reg_m[i] = d & rmask(i);
    hr(1'b1, reg_m[i]);
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
    k++;
    if (k > 400) begin
      bad_count++;
      summarize();
    end
  endtask

  // Counts clocks, dots and characters over one shift register reload period.
  task automatic meas(input int dots, input int rate, input int dv);
    int cyc, dc, cc;
    cyc = 0;
    dc = 0;
    cc = 0;
    k = 0;
    while (shift_load !== 1'b1)
      tick();
    do begin
      tick();
      cyc++;
      dc += int'(dot_en === 1'b1);
      cc += int'(char_clk === 1'b1);
    end while (shift_load !== 1'b1);
    chk(32'(cyc), 32'(rate * dots * dv));
    chk(32'(dc), 32'(rate * dots));
    chk(32'(cc), 32'(rate));
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {host_wr, host_rd, host_sel_data, host_wdata} = '0;
    {ext_mem_en, force_8dot, mem_wr, mem_rd, mem_addr} = '0;
    attr_in = 8'h00;
    pan_in = 4'h0;
    bad_count = 0;
    n_compared = 0;
    for (n = 0; n < 8; n++)
      reg_m[n] = 8'h00;
    void'($urandom(32'h3d61));
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    for (n = 0; n < 8; n++)
      rreg(n);
    for (n = 0; n < 24; n++) begin
      c = int'($urandom % 8);
      wreg(c, 8'($urandom));
      rreg(c);
    end
    for (n = 0; n < 6; n++) begin
      wr_rd(2, n == 0 ? 8'h00 : 8'($urandom));
      for (c = 0; c < 12; c++) begin
        mem_wr = 1'($urandom);
        mem_rd = 1'($urandom);
        mem_addr = 18'($urandom);
        ext_mem_en = 1'($urandom);
        ok = ext_mem_en || mem_addr[17:16] == 2'h0;
        @(posedge clk);
        #1;
        chk(32'(plane_we), mem_wr && ok ? 32'(reg_m[2][3:0]) : 32'h0);
        chk(32'(mem_rd_ok), 32'(mem_rd && ok));
      end
    end
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    for (n = 0; n < 20; n++) begin
      wreg(3, 8'($urandom));
      wreg(1, 8'($urandom));
      ext_mem_en = 1'($urandom);
      force_8dot = 1'($urandom);
      repeat (2) @(posedge clk);
      #1;
      for (c = 0; c < 6; c++) begin
        attr_in = 8'($urandom);
        pan_in = 4'($urandom);
        fa = {reg_m[3][4], reg_m[3][1:0]};
        fb = {reg_m[3][5], reg_m[3][3:2]};
        if (!ext_mem_en) begin
          fa[1:0] = 2'h0;
          fb[1:0] = 2'h0;
        end
        spl = fa != fb;
        if (spl && !attr_in[3])
          fa = fb;
        nar = reg_m[1][0] | force_8dot;
        pe = nar ? {1'b0, pan_in[2:0]}
                 : (pan_in < 4'h8 ? pan_in + 4'h1 : 4'h0);
        @(posedge clk);
        #1;
        chk(32'(font_offset), {16'h0,fa[1:0],fa[2],13'h0});
        chk(32'(font_split), 32'(spl));
        chk(32'(fg_bright), 32'(!spl && attr_in[3]));
        chk(32'(pan_shift), 32'(pe));
        chk(32'(narrow_char), 32'(nar));
      end
    end
    for (c = 0; c < 32; c++) begin
      wreg(1, {3'h0, c[3], c[0], c[2], 1'b0, c[1]});
      force_8dot = c[4];
      repeat (80) @(posedge clk);
      #1;
      meas((c[1] | c[4]) ? 8 : 9, c[3] ? 4 : (c[2] ? 2 : 1), c[0] ? 2 : 1);
    end
    summarize();
  end
endmodule
